// ### src/video_source_select_freeze.sv
// input stage: crosspoint, source select, flip, freeze, blur, aspect and blanking
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module video_source_select_freeze
  import vsel_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  // avalon-mm slave
  input  wire logic [7:0]                   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  // timing and inputs
  input  wire logic                         field_start,
  input  wire logic                         field_two,
  input  wire logic                         hd_mode,
  input  wire logic                         second_input_module,
  input  wire logic [NUM_XP_IN*vsel_pkg::PIX_W-1:0] xp_in_data,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [SEL_W-1:0]             aux_bus_crosspoint_select,
  // outputs
  output logic [NUM_XP_OUT*vsel_pkg::PIX_W-1:0] xp_out_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [NUM_CH*2-1:0]               ch_flip_h_v,
  output logic [NUM_CH*14-1:0]              ch_blur,
  output logic [15:0]                       aspect_h,
  output logic [15:0]                       aspect_v,
  output logic                              aspect_rescale,
  output logic [15:0]                       edge_comp,
  output logic                              uniform_edge_trim_mode
);
  import vsel_pkg::*;

  localparam int XW = NUM_XP_OUT * PIX_W;

  // shadow (software) and live (applied) settings
  logic [31:0] sel_shadow_q [NUM_CH];
  logic [31:0] sel_live_q   [NUM_CH];
  logic [31:0] frz_shadow_q [NUM_CH];
  logic [31:0] frz_live_q   [NUM_CH];
  logic [15:0] route_q;
  logic [31:0] cfg_q;
  logic [15:0] blank_q [NUM_EXT];
  logic [31:0] aspect_q;
  logic        aspect_user_q;
  logic        pend_q;
  logic        rescale_q;
  frz_state_t  frz_st_q [NUM_CH];
  logic [7:0]  strobe_cnt_q [NUM_CH];
  logic [SEL_W-1:0] frz_src_q [NUM_CH];
  logic [PIX_W-1:0] frz_pix_q [NUM_CH];
  logic        frame_tick;

  // number of fitted inputs
  function automatic logic [SEL_W:0] num_ext(input logic second);
    num_ext = second ? 5'(NUM_EXT) : {1'b0, BASE_EXT};
  endfunction

  // map type and source field to a crosspoint input
  function automatic logic [SEL_W-1:0] map_src(input logic [2:0] typ,
                                               input logic [SEL_W-1:0] src,
                                               input logic [SEL_W-1:0] aux,
                                               input logic second);
    case (typ)
      SRC_VIDEO:   map_src = ({1'b0, src} < num_ext(second)) ? src : 4'h0;
      SRC_PATTERN: map_src = XP_IN_PATTERN;
      SRC_MATTE:   map_src = XP_IN_MATTE;
      SRC_DEFOC_A: map_src = XP_IN_DEFOC_A;
      SRC_DEFOC_B: map_src = XP_IN_DEFOC_B;
      SRC_AUX:     map_src = aux;
      default:     map_src = 4'h0;
    endcase
  endfunction

  // pick one sample from the input bus
  function automatic logic [PIX_W-1:0] pick(input logic [NUM_XP_IN*PIX_W-1:0] bus,
                                            input logic [SEL_W-1:0] idx);
    pick = bus[idx*PIX_W +: PIX_W];
  endfunction

  // frame boundary: first field of a frame
  assign frame_tick = field_start & ~field_two;

  // bus slave: one wait cycle for every access
  logic ack_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_q       <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      ack_q       <= (read | write) & ~ack_q;
      waitrequest <= ~((read | write) & ~ack_q); // low in the answer cycle
    end
  end
  wire wr_en = write & ack_q;

  // software writes: shadow selections and freezes, other settings direct
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        sel_shadow_q[i] <= 32'h0;
        frz_shadow_q[i] <= FRZ_RESET;
      end
      route_q <= 16'h0;
      cfg_q   <= 32'h0;
      for (int i = 0; i < NUM_EXT; i++) blank_q[i] <= 16'h0;
      aspect_q      <= 32'h0;
      aspect_user_q <= 1'b0;
      pend_q        <= 1'b0;
      rescale_q     <= 1'b0;
    end else begin
      rescale_q <= 1'b0;
      // clear first so a write in the same cycle wins
      if (field_start) pend_q <= 1'b0;
      if (wr_en) begin
        if (address < REG_FRZ) begin
          sel_shadow_q[address[3:2]] <= writedata;
          pend_q <= 1'b1;
        end else if (address < REG_ROUTE) begin
          frz_shadow_q[address[3:2]] <= writedata;
          pend_q <= 1'b1;
        end else if (address == REG_ROUTE) begin
          route_q <= writedata[15:0];
        end else if (address == REG_CFG) begin
          cfg_q <= writedata;
        end else if (address == REG_BLANK) begin
          if (writedata[19:16] < 4'(NUM_EXT)) blank_q[writedata[19:16]] <= writedata[15:0];
        end else if (address == REG_ASPECT) begin
          aspect_q      <= writedata;
          aspect_user_q <= 1'b1;
          rescale_q     <= 1'b1;
        end
      end
    end
  end

  // apply shadow selections only at a boundary
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        sel_live_q[i] <= 32'h0;
        frz_live_q[i] <= FRZ_RESET;
      end
    end else if (field_start) begin
      for (int i = 0; i < NUM_CH; i++) begin
        sel_live_q[i] <= sel_shadow_q[i];
        frz_live_q[i] <= frz_shadow_q[i];
      end
    end
  end

  // freeze state machine per channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        frz_st_q[i]     <= ST_LIVE;
        strobe_cnt_q[i] <= 8'h0;
        frz_src_q[i]    <= 4'h0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        case (frz_st_q[i])
          ST_LIVE: begin
            if (frz_live_q[i][FRZ_MODE +: 2] != FRZ_OFF && field_start) begin
              frz_st_q[i]  <= ST_CAPTURE;
              frz_src_q[i] <= map_src(sel_live_q[i][SEL_NEAR_TYPE +: 3],
                                      sel_live_q[i][SEL_NEAR_SRC +: 4],
                                      aux_bus_crosspoint_select, second_input_module);
            end
          end
          ST_CAPTURE: begin
            // capture the selected field or whole frame
            if (field_start) begin
              case (frz_mode_t'(frz_live_q[i][FRZ_MODE +: 2]))
                FRZ_FLD1: if (field_two) frz_st_q[i] <= ST_HOLD;
                FRZ_FLD2: if (!field_two) frz_st_q[i] <= ST_HOLD;
                FRZ_FRM:  if (!field_two) frz_st_q[i] <= ST_HOLD;
                default:  frz_st_q[i] <= ST_LIVE;
              endcase
              strobe_cnt_q[i] <= 8'h0;
            end
          end
          ST_HOLD: begin
            if (frz_live_q[i][FRZ_MODE +: 2] == FRZ_OFF) begin
              frz_st_q[i] <= ST_LIVE;
            end else if (frame_tick &&
                         frz_live_q[i][FRZ_STROBE +: 8] != STROBE_INFINITE) begin
              if (strobe_cnt_q[i] >= frz_live_q[i][FRZ_STROBE +: 8]) begin
                frz_st_q[i] <= ST_CAPTURE;
              end else begin
                strobe_cnt_q[i] <= strobe_cnt_q[i] + 8'h1;
              end
            end
          end
          default: frz_st_q[i] <= ST_LIVE;
        endcase
      end
    end
  end

  // two-entry output buffer
  logic [XW-1:0] buf_q [2];
  logic [1:0]    cnt_q;
  logic [1:0]    cnt_d;
  logic          rd_q, wr_q;
  logic [XW-1:0] route_data;
  logic          push, pop;
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;

  // crosspoint assembly of one word
  always_comb begin
    logic [SEL_W-1:0] s;
    logic [PIX_W-1:0] pix;
    s = 4'h0;
    pix = '0;
    route_data = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (frz_st_q[c] != ST_LIVE) begin
        s = frz_src_q[c];
      end else begin
        s = map_src(sel_live_q[c][SEL_NEAR_TYPE +: 3], sel_live_q[c][SEL_NEAR_SRC +: 4],
                    aux_bus_crosspoint_select, second_input_module);
      end
      pix = pick(xp_in_data, s);
      if (frz_st_q[c] == ST_HOLD) pix = frz_pix_q[c];
      route_data[c*PIX_W +: PIX_W] = pix;
      s = map_src(sel_live_q[c][SEL_FAR_TYPE +: 3], sel_live_q[c][SEL_FAR_SRC +: 4],
                  aux_bus_crosspoint_select, second_input_module);
      if (frz_st_q[c] != ST_LIVE) s = frz_src_q[c];
      pix = (frz_st_q[c] == ST_HOLD) ? frz_pix_q[c] : pick(xp_in_data, s);
      route_data[(XP_OUT_TEX0 + c)*PIX_W +: PIX_W] = pix;
    end
    route_data[XP_OUT_BG*PIX_W +: PIX_W]  = pick(xp_in_data, route_q[3:0]);
    route_data[XP_OUT_DFA*PIX_W +: PIX_W] = pick(xp_in_data, route_q[7:4]);
    route_data[XP_OUT_DFB*PIX_W +: PIX_W] = pick(xp_in_data, route_q[11:8]);
  end

  // buffer storage and its fill count
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cnt_q    <= 2'd0;
      in_ready <= 1'b1;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= route_data;
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != 2'd2); // refuse only when both entries are taken
    end
  end

  // frame store stand-in: last pixel taken while capturing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) frz_pix_q[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (push && frz_st_q[i] == ST_CAPTURE) frz_pix_q[i] <= pick(xp_in_data, frz_src_q[i]);
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xp_out_data <= '0;
      out_valid   <= 1'b0;
    end else begin
      if (!out_valid || out_ready) begin
        out_valid   <= 1'b0;
        if (cnt_q != 2'd0 && !(out_valid && cnt_q == 2'd1)) begin
          out_valid   <= 1'b1;
          xp_out_data <= buf_q[out_valid ? ~rd_q : rd_q];
        end
      end
    end
  end

  // per channel flip and blur settings
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch_flip_h_v <= '0;
      ch_blur     <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        ch_flip_h_v[c*2 +: 2] <= sel_live_q[c][SEL_FLIP +: 2];
        ch_blur[c*14 +: 7] <= (sel_live_q[c][SEL_BLUR_H +: 7] > BLUR_MAX) ?
                              BLUR_MAX : sel_live_q[c][SEL_BLUR_H +: 7];
        ch_blur[c*14+7 +: 7] <= (sel_live_q[c][SEL_BLUR_V +: 7] > BLUR_MAX) ?
                                BLUR_MAX : sel_live_q[c][SEL_BLUR_V +: 7];
      end
    end
  end

  // aspect, blanking mode and compensation of the selected input
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aspect_h               <= 16'h0;
      aspect_v               <= 16'h0;
      aspect_rescale         <= 1'b0;
      edge_comp              <= 16'h0;
      uniform_edge_trim_mode <= 1'b0;
    end else begin
      if (aspect_user_q) begin
        aspect_h <= aspect_q[31:16];
        aspect_v <= aspect_q[15:0];
      end else begin
        aspect_h <= hd_mode ? ASP_HD_H : ASP_SD_H;
        aspect_v <= hd_mode ? ASP_HD_V : ASP_SD_V;
      end
      aspect_rescale         <= rescale_q;
      uniform_edge_trim_mode <= cfg_q[0];
      // crop: common amount; normal: per input of channel 0 source
      edge_comp <= cfg_q[0] ? cfg_q[31:16] :
                   blank_q[sel_live_q[0][SEL_NEAR_SRC +: 4] % 4'(NUM_EXT)];
    end
  end

  // read data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (read && !ack_q) begin
      if (address < REG_FRZ)        readdata <= sel_shadow_q[address[3:2]];
      else if (address < REG_ROUTE) readdata <= frz_shadow_q[address[3:2]];
      else if (address == REG_ROUTE)  readdata <= {16'h0, route_q};
      else if (address == REG_CFG)    readdata <= cfg_q;
      else if (address == REG_ASPECT) readdata <= aspect_q;
      else if (address == REG_STATUS) readdata <= {27'h0, pend_q, aspect_user_q,
                                                   second_input_module, hd_mode, field_two};
      else if (address == REG_CHSTAT) readdata <= {20'h0, frz_st_q[3], frz_st_q[2],
                                                   frz_st_q[1], frz_st_q[0]};
      else readdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### src/vsel_pkg.sv
// constants and types for the video source select and freeze block
package vsel_pkg;
  localparam int PIX_W       = 10;  // video sample width
  localparam int NUM_EXT     = 12;  // external inputs
  localparam int NUM_XP_IN   = 16;  // crosspoint inputs
  localparam int NUM_XP_OUT  = 11;  // crosspoint outputs
  localparam int NUM_CH      = 4;   // effect channels
  localparam int SEL_W       = 4;
  localparam int XP_OUT_W    = 4;
  // crosspoint input numbering
  localparam logic [SEL_W-1:0] XP_IN_MATTE   = 4'hc;
  localparam logic [SEL_W-1:0] XP_IN_PATTERN = 4'hd;
  localparam logic [SEL_W-1:0] XP_IN_DEFOC_A = 4'he;
  localparam logic [SEL_W-1:0] XP_IN_DEFOC_B = 4'hf;
  localparam logic [SEL_W-1:0] BASE_EXT      = 4'h6;  // inputs fitted without second module
  // crosspoint outputs: 0..3 channels, 4..7 texture, 8 background, 9..10 defocus in
  localparam logic [XP_OUT_W-1:0] XP_OUT_TEX0 = 4'h4;
  localparam logic [XP_OUT_W-1:0] XP_OUT_BG   = 4'h8;
  localparam logic [XP_OUT_W-1:0] XP_OUT_DFA  = 4'h9;
  localparam logic [XP_OUT_W-1:0] XP_OUT_DFB  = 4'ha;
  // register map, byte addresses (word aligned)
  localparam logic [7:0] REG_SEL     = 8'h00;  // per channel: +4*ch
  localparam logic [7:0] REG_FRZ     = 8'h10;  // per channel: +4*ch
  localparam logic [7:0] REG_ROUTE   = 8'h20;  // aux destinations
  localparam logic [7:0] REG_CFG     = 8'h24;
  localparam logic [7:0] REG_BLANK   = 8'h28;  // per input blanking, index field
  localparam logic [7:0] REG_ASPECT  = 8'h2c;
  localparam logic [7:0] REG_STATUS  = 8'h30;
  localparam logic [7:0] REG_CHSTAT  = 8'h34;
  // field positions in REG_SEL
  localparam int SEL_NEAR_TYPE = 0;   // 3 bits
  localparam int SEL_NEAR_SRC  = 4;   // 4 bits
  localparam int SEL_FAR_TYPE  = 8;
  localparam int SEL_FAR_SRC   = 12;
  localparam int SEL_FLIP      = 16;  // 2 bits
  localparam int SEL_BLUR_H    = 18;  // 7 bits
  localparam int SEL_BLUR_V    = 25;  // 7 bits
  // field positions in REG_FRZ
  localparam int FRZ_MODE      = 0;   // 2 bits
  localparam int FRZ_STROBE    = 8;   // 8 bits, 8'hff means hold forever
  localparam logic [7:0] STROBE_INFINITE = 8'hff;
  localparam logic [6:0] BLUR_MAX  = 7'd100;
  // aspect defaults, h and v in 8.8 fixed point
  localparam logic [15:0] ASP_HD_H = 16'h1000;  // 16
  localparam logic [15:0] ASP_HD_V = 16'h0900;  // 9
  localparam logic [15:0] ASP_SD_H = 16'h0100;  // 1
  localparam logic [15:0] ASP_SD_V = 16'h00c0;  // .75
  localparam logic [31:0] FRZ_RESET = 32'h0000ff00;

  typedef enum logic [2:0] {
    SRC_VIDEO   = 3'd0,
    SRC_PATTERN = 3'd1,
    SRC_MATTE   = 3'd2,
    SRC_DEFOC_A = 3'd3,
    SRC_DEFOC_B = 3'd4,
    SRC_AUX     = 3'd5
  } src_type_t;

  typedef enum logic [1:0] {
    FRZ_OFF  = 2'd0,
    FRZ_FLD1 = 2'd1,
    FRZ_FLD2 = 2'd2,
    FRZ_FRM  = 2'd3
  } frz_mode_t;

  typedef enum logic [2:0] {
    ST_LIVE    = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_HOLD    = 3'b100
  } frz_state_t;
endpackage

// ### tb/testbench.sv
// self-checking bench for the source select and freeze block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import vsel_pkg::*;
  typedef struct packed {logic [1:0] ch; logic [1:0] flip; logic [6:0] blur; logic [6:0] want;} row_t;
  logic         clock, rst_b, read, write, waitrequest, field_start, field_two;
  logic         in_valid, in_ready, out_valid, out_ready, stall, aspect_rescale, trim;
  logic [7:0]   address, ch_flip_h_v;
  logic [31:0]  writedata, readdata, q;
  logic [3:0]   aux_sel;
  logic [55:0]  ch_blur;
  logic [15:0]  aspect_h, aspect_v, edge_c;
  logic [159:0] xp_in_data;
  logic [109:0] xp_out_data;
  logic [4:0]   exp_idx [0:10];
  logic [5:0]   prev_seq;
  logic [9:0]   frz_val;
  logic         live_on, frz_on, have_prev;
  int           failures, total_checks, words, rescale_cnt;
  row_t rows [4] = '{'{0, 0, 0, 0}, '{1, 1, 50, 50}, '{2, 2, 100, 100}, '{3, 3, 127, 100}};
  video_source_select_freeze i_dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .field_start(field_start), .field_two(field_two), .hd_mode(1'b0), .second_input_module(1'b1),
    .xp_in_data(xp_in_data), .in_valid(in_valid), .in_ready(in_ready),
    .aux_bus_crosspoint_select(aux_sel), .xp_out_data(xp_out_data), .out_valid(out_valid),
    .out_ready(out_ready), .ch_flip_h_v(ch_flip_h_v), .ch_blur(ch_blur), .aspect_h(aspect_h),
    .aspect_v(aspect_v), .aspect_rescale(aspect_rescale), .edge_comp(edge_c),
    .uniform_edge_trim_mode(trim));
  video_src_model i_src (.clock(clock), .rst_b(rst_b), .in_ready(in_ready), .stall(stall),
    .xp_in_data(xp_in_data), .in_valid(in_valid), .out_ready(out_ready));
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("ERROR %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    v = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) check(1'b0, 1'b1, "bus answer");
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want, input string what);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, want, what);
  endtask
  task automatic sel(input logic [1:0] ch, input src_type_t t, input logic [3:0] s,
                     input logic [3:0] e);
    bus(1'b1, REG_SEL + {4'h0, ch, 2'b00}, {16'h0000, s, 1'b0, t, s, 1'b0, t}, q);
    exp_idx[ch] = {1'b1, e};
    exp_idx[ch + 4] = {1'b1, e};
  endtask
  task automatic field();
    @(posedge clock);
    field_start <= 1'b1;
    field_two <= !field_two;
    @(posedge clock);
    field_start <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wait_words(input int n);
    int start;
    int c;
    start = words;
    c = 0;
    while (words < start + n && c < 2000) begin
      @(posedge clock);
      c++;
    end
    check(words >= start + n, 1'b1, "word flow");
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
  // watch every accepted output word
  always @(posedge clock) begin
    if (rst_b && out_valid === 1'b1 && out_ready === 1'b1) begin
      words++;
      for (int k = 0; k < NUM_XP_OUT; k++) begin
        if (live_on && exp_idx[k][4]) check(xp_out_data[k*PIX_W +: 4], exp_idx[k][3:0], "route");
      end
      if (live_on && have_prev) check(xp_out_data[9:4], 6'(prev_seq + 6'h01), "word lost");
      if (frz_on && have_prev) check(xp_out_data[9:0], frz_val, "frozen picture");
      prev_seq = xp_out_data[9:4];
      frz_val = xp_out_data[9:0];
      have_prev = 1'b1;
    end
    if (aspect_rescale === 1'b1) rescale_cnt++;
  end
  initial begin
    {read, write, field_start, field_two, stall, live_on, frz_on, have_prev} = '0;
    address = 8'h00;
    writedata = 32'h0;
    aux_sel = 4'h9;
    foreach (exp_idx[k]) exp_idx[k] = 5'h00;
    rst_b = 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    check(waitrequest, 1'b1, "wait idle");
    check(ch_flip_h_v, 8'h00, "flip reset");
    check(ch_blur === '0, 1'b1, "blur reset");
    rdc(REG_SEL, 32'h0, "select reset");
    rdc(REG_FRZ, FRZ_RESET, "freeze reset");
    check(aspect_h, ASP_SD_H, "aspect default h");
    check(aspect_v, ASP_SD_V, "aspect default v");
    bus(1'b1, 8'h40, 32'hffffffff, q);
    rdc(8'h40, 32'h0, "unmapped");
    // flip and blur rows, one per channel
    foreach (rows[r]) bus(1'b1, REG_SEL + {4'h0, rows[r].ch, 2'b00},
                          {rows[r].blur, rows[r].blur, rows[r].flip, 16'h0000}, q);
    check(ch_flip_h_v, 8'h00, "flip before boundary");
    field();
    foreach (rows[r]) begin
      check(ch_flip_h_v[rows[r].ch*2 +: 2], rows[r].flip, "flip");
      check(ch_blur[rows[r].ch*14 +: 14], {rows[r].want, rows[r].want}, "blur");
    end
    // every source type, near and far per channel
    sel(0, SRC_VIDEO, 4'h3, 4'h3);
    sel(1, SRC_AUX, 4'h0, 4'h9);
    sel(2, SRC_MATTE, 4'h0, XP_IN_MATTE);
    sel(3, SRC_PATTERN, 4'h0, XP_IN_PATTERN);
    bus(1'b1, REG_BLANK, 32'h00030010, q);
    bus(1'b1, REG_ROUTE, 32'h00000b17, q);
    exp_idx[8] = 5'h17;
    exp_idx[9] = 5'h11;
    exp_idx[10] = 5'h1b;
    field();
    check(edge_c, 16'h0010, "edge comp");
    live_on = 1'b1;
    wait_words(40);
    // receiver stalls until the buffer refuses
    stall <= 1'b1;
    for (int c = 0; c < 20 && in_ready !== 1'b0; c++) @(posedge clock);
    check(in_ready, 1'b0, "buffer full");
    stall <= 1'b0;
    wait_words(20);
    live_on = 1'b0;
    sel(2, SRC_DEFOC_A, 4'h0, XP_IN_DEFOC_A);
    sel(3, SRC_DEFOC_B, 4'h0, XP_IN_DEFOC_B);
    field();
    have_prev = 1'b0;
    live_on = 1'b1;
    wait_words(20);
    live_on = 1'b0;
    // each freeze mode holds the picture
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, REG_FRZ, {16'h0000, STROBE_INFINITE, 6'h00, m[1:0]}, q);
      repeat (4) field();
      wait_words(4);
      have_prev = 1'b0;
      frz_on = 1'b1;
      wait_words(8);
      frz_on = 1'b0;
    end
    sel(0, SRC_VIDEO, 4'h4, 4'h4);
    field();
    have_prev = 1'b0;
    frz_on = 1'b1;
    wait_words(10);
    frz_on = 1'b0;
    bus(1'b1, REG_FRZ, FRZ_RESET, q);
    field();
    wait_words(4);
    have_prev = 1'b0;
    live_on = 1'b1;
    wait_words(10);
    // aspect values and the rescale pulse
    bus(1'b1, REG_ASPECT, 32'h04000300, q);
    repeat (3) @(posedge clock);
    check(aspect_h, 16'h0400, "aspect h");
    check(aspect_v, 16'h0300, "aspect v");
    check(rescale_cnt, 1, "rescale");
    rdc(REG_ASPECT, 32'h04000300, "aspect read");
    bus(1'b1, REG_CFG, 32'h00200001, q);
    field();
    check(trim, 1'b1, "trim mode");
    check(edge_c, 16'h0020, "trim amount");
    wait_words(10);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### tb/video_src_model.sv
// far side model: video sources feeding the block and the stream receiver
`timescale 1ns/100ps
`default_nettype none
module video_src_model (
  input  wire logic                                              clock,
  input  wire logic                                              rst_b,
  input  wire logic                                              in_ready,
  input  wire logic                                              stall,
  output logic [vsel_pkg::NUM_XP_IN*vsel_pkg::PIX_W-1:0]       xp_in_data,
  output logic                                                   in_valid,
  output logic                                                   out_ready
);
  import vsel_pkg::*;
  logic [5:0]                 seq_q;
  logic [5:0]                 seq_d;
  logic [2:0]                 cyc_q;
  logic [NUM_XP_IN*PIX_W-1:0] word;
  // next sequence number once the offered word is taken
  assign seq_d = seq_q + {5'h00, in_valid && in_ready};
  // each input sample: sequence number above the input index
  always_comb begin
    for (int i = 0; i < NUM_XP_IN; i++) word[i*PIX_W +: PIX_W] = {seq_d, i[3:0]};
  end
  // sources pause now and then, receiver stalls on a fixed beat or on command
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= 6'h00;
      cyc_q <= 3'h0;
      in_valid <= 1'b0;
      xp_in_data <= '0;
      out_ready <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cyc_q <= cyc_q + 3'h1;
      out_ready <= !stall && (cyc_q != 3'h5);
      if (in_valid && !in_ready) begin
        in_valid <= 1'b1; // hold the word until taken
      end else if (cyc_q == 3'h2) begin
        in_valid <= 1'b0;
        xp_in_data <= ~xp_in_data; // no stale data while idle
      end else begin
        in_valid <= 1'b1;
        xp_in_data <= word;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/vsel_chk.sv
// port checker for the source select and freeze block
`timescale 1ns/100ps
`default_nettype none
module vsel_chk (
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic [7:0]   address,
  input wire logic         read,
  input wire logic         write,
  input wire logic [31:0]  readdata,
  input wire logic         waitrequest,
  input wire logic         in_ready,
  input wire logic         out_valid,
  input wire logic         out_ready,
  input wire logic [109:0] xp_out_data,
  input wire logic         field_start,
  input wire logic [7:0]   ch_flip_h_v,
  input wire logic [55:0]  ch_blur,
  input wire logic         aspect_rescale
);
  import vsel_pkg::*;
  logic blur_over;
  logic asp_wr;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // aspect write accepted this cycle
  assign asp_wr = write && !waitrequest && (address == REG_ASPECT);
  // any blur field above the top level
  always_comb begin
    blur_over = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (ch_blur[i*7 +: 7] > BLUR_MAX) blur_over = 1'b1;
    end
  end
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest stayed high after a request");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(xp_out_data))
    else $error("output word changed while stalled");
  full_stall_a: assert property ($fell(in_ready) |-> out_valid)
    else $error("input refused with no word waiting");
  unmapped_read_a: assert property (read && !waitrequest && address >= 8'h38 |-> readdata == '0)
    else $error("unmapped read returned data");
  blur_clamp_a: assert property (!blur_over)
    else $error("blur level above maximum");
  flip_boundary_a: assert property (!$stable(ch_flip_h_v) |-> $past(field_start) || $past(field_start, 2))
    else $error("flip changed away from a field boundary");
  rescale_pulse_a: assert property (aspect_rescale |=> !aspect_rescale)
    else $error("rescale pulse longer than one cycle");
  rescale_cause_a: assert property (aspect_rescale |-> $past(asp_wr) || $past(asp_wr, 2))
    else $error("rescale without an aspect write");
  cover property (!in_ready);
  cover property (aspect_rescale);
  cover property (out_valid && !out_ready);
endmodule
bind video_source_select_freeze vsel_chk i_chk (.clock(clock), .rst_b(rst_b), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .xp_out_data(xp_out_data),
  .field_start(field_start), .ch_flip_h_v(ch_flip_h_v), .ch_blur(ch_blur),
  .aspect_rescale(aspect_rescale));
`default_nettype wire
